// [dtp_dual_timebase_pwm.sv]
`timescale 1ns/1ps
module dtp_dual_timebase_pwm #(
	parameter int TICK_DIV = dtp_pkg::TICK_DIV
) (
	input  wire logic                      mclk,       // 200 MHz clock
	input  wire logic                      reset,      // Synchronous, active high
	input  wire logic                      psel,       // APB select
	input  wire logic                      penable,    // APB access phase
	input  wire logic                      pwrite,     // APB direction
	input  wire logic [dtp_pkg::ADDR_W-1:0] paddr,     // APB byte address
	input  wire logic [31:0]               pwdata,     // APB write data
	output logic      [31:0]               prdata,     // APB read data
	output logic                           pready,     // APB ready
	output logic                           pslverr,    // Unmapped access
	input  wire logic                      hwOneIn,    // Channel one pin level
	output logic                           hwOneOut,   // Channel one pin drive
	output logic                           hwOneOe,    // Channel one drive enable
	output logic                           hwTwoOut,   // Channel two pin drive
	output logic                           hwTwoOe,    // Channel two drive enable
	output logic                           swThreeOut, // Channel three on sink pin
	output logic                           swThreeOe,  // Channel three owns pin
	output logic                           swFourOut,  // Channel four on general pin
	output logic                           swFourOe    // Channel four owns pin
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	dtp_pkg::dtp_unit_cfg_t unitCfg [2];
	logic                   analogOn;
	logic                   sinkOn;
	logic                   genIoOn;
	logic [15:0]            wide [dtp_pkg::WIDE_N];
	logic [7:0]             stage [dtp_pkg::WIDE_N];
	logic [5:0]             idx;
	logic                   wrEn;
	logic                   isWide;
	logic [2:0]             wideSel;
	logic [7:0]             rdByte;
	logic                   pinMeta;
	logic                   pinSync;
	logic [7:0]             tickCnt;
	logic                   timerTick;
	logic [15:0]            cnt [2];
	logic [15:0]            cycAct [2];
	logic [15:0]            widthAct [2][2];
	logic                   unitTick [2];
	logic                   wrap [2];
	logic                   act [2][2];

	// Mask of low prescaler bits that must all be set for a unit tick
	function automatic logic [dtp_pkg::PRE_W-1:0] divMask(input logic [dtp_pkg::DIV_W-1:0] sel);
		logic [dtp_pkg::PRE_W:0] one;
		one = {{dtp_pkg::PRE_W{1'b0}}, 1'b1};
		divMask = dtp_pkg::PRE_W'((one << sel) - one);
	endfunction : divMask

	// Cycle lengths of zero would make the counter run 65536 ticks, so they are lifted to one
	function automatic logic [15:0] clampWide(input logic [2:0] sel, input logic [15:0] v);
		if ((sel < 3'h2) && (v < dtp_pkg::CYCLE_MIN))
			clampWide = dtp_pkg::CYCLE_MIN;
		else
			clampWide = v;
	endfunction : clampWide

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Zero-wait slave: every access completes in its first access cycle
	assign idx     = paddr[dtp_pkg::ADDR_W-1:2];
	assign wrEn    = psel && penable && pwrite;
	assign isWide  = (idx >= dtp_pkg::IDX_WIDE_FIRST) && (idx <= dtp_pkg::IDX_WIDE_LAST);
	assign wideSel = 3'((idx - dtp_pkg::IDX_WIDE_FIRST) >> 1);
	assign pready  = 1'b1;

	// Unmapped indices answer with an error and read as zero
	always_comb
	begin
		pslverr = psel && penable;
		if (isWide || (idx == dtp_pkg::IDX_ANALOG_CFG) || (idx == dtp_pkg::IDX_SINK_CFG)
			|| (idx == dtp_pkg::IDX_GEN_IO_CFG) || (idx == dtp_pkg::IDX_UNIT_A_CFG)
			|| (idx == dtp_pkg::IDX_UNIT_B_CFG))
			pslverr = 1'b0;
	end

	// Read mux; in sensing mode the invert bit shows the pin instead
	always_comb
	begin
		rdByte = 8'h00;
		if (isWide)
			rdByte = idx[0] ? wide[wideSel][7:0] : wide[wideSel][15:8];
		else
		begin
			unique case (idx)
				dtp_pkg::IDX_ANALOG_CFG: rdByte[dtp_pkg::FUNC_ON_BIT] = analogOn;
				dtp_pkg::IDX_SINK_CFG:   rdByte[dtp_pkg::FUNC_ON_BIT] = sinkOn;
				dtp_pkg::IDX_GEN_IO_CFG: rdByte[dtp_pkg::FUNC_ON_BIT] = genIoOn;
				dtp_pkg::IDX_UNIT_A_CFG:
				begin
					rdByte[dtp_pkg::CFG_INVERT]  = (unitCfg[0].modOff && unitCfg[0].senseIn)
						? pinSync : unitCfg[0].invert;
					rdByte[dtp_pkg::CFG_SENSE]   = unitCfg[0].senseIn;
					rdByte[dtp_pkg::CFG_MOD_OFF] = unitCfg[0].modOff;
					rdByte[2:0]                  = unitCfg[0].divSel;
				end
				dtp_pkg::IDX_UNIT_B_CFG:
				begin
					rdByte[dtp_pkg::CFG_INVERT]  = unitCfg[1].invert;
					rdByte[dtp_pkg::CFG_MOD_OFF] = unitCfg[1].modOff;
					rdByte[2:0]                  = unitCfg[1].divSel;
				end
				default: rdByte = 8'h00;
			endcase
		end
	end

	// Read data is captured in the setup cycle so it stands from a flop
	always_ff @(posedge mclk)
	begin
		if (reset)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= {24'h00_0000, rdByte};
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Unknown indices fall through, so stray writes leave state alone
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			unitCfg[0] <= '0;
			unitCfg[1] <= '0;
			analogOn   <= 1'b0;
			sinkOn     <= 1'b0;
			genIoOn    <= 1'b0;
		end
		else if (wrEn)
		begin
			unique case (idx)
				dtp_pkg::IDX_ANALOG_CFG: analogOn <= pwdata[dtp_pkg::FUNC_ON_BIT];
				dtp_pkg::IDX_SINK_CFG:   sinkOn   <= pwdata[dtp_pkg::FUNC_ON_BIT];
				dtp_pkg::IDX_GEN_IO_CFG: genIoOn  <= pwdata[dtp_pkg::FUNC_ON_BIT];
				dtp_pkg::IDX_UNIT_A_CFG:
					unitCfg[0] <= '{pwdata[dtp_pkg::CFG_INVERT], pwdata[dtp_pkg::CFG_SENSE],
						pwdata[dtp_pkg::CFG_MOD_OFF], pwdata[2:0]};
				dtp_pkg::IDX_UNIT_B_CFG:
					unitCfg[1] <= '{pwdata[dtp_pkg::CFG_INVERT], 1'b0,
						pwdata[dtp_pkg::CFG_MOD_OFF], pwdata[2:0]}; // Sensing only on unit A
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// 16-bit registers: high byte staged, low byte commits
	// ----------------------------------------------------------------
	// Staging keeps a half-written value from ever reaching the counters
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			for (int i = 0; i < dtp_pkg::WIDE_N; i++)
			begin
				wide[i]  <= (i < 2) ? dtp_pkg::CYCLE_RST : dtp_pkg::WIDTH_RST;
				stage[i] <= 8'h00;
			end
		end
		else if (wrEn && isWide)
		begin
			if (!idx[0])
				stage[wideSel] <= pwdata[7:0];
			else
				wide[wideSel] <= clampWide(wideSel, {stage[wideSel], pwdata[7:0]});
		end
	end

	// ----------------------------------------------------------------
	// Pin input synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
		end
		else
		begin
			pinMeta <= hwOneIn;
			pinSync <= pinMeta;
		end
	end

	// ----------------------------------------------------------------
	// Timer clock strobe
	// ----------------------------------------------------------------
	// Integer division of mclk; 200 MHz gives 16.67 MHz, a known limitation
	always_ff @(posedge mclk)
	begin
		if (reset)
			tickCnt <= 8'h00;
		else if (tickCnt >= 8'(TICK_DIV - 1))
			tickCnt <= 8'h00;
		else
			tickCnt <= tickCnt + 8'h01;
	end
	assign timerTick = (tickCnt >= 8'(TICK_DIV - 1));

	// ----------------------------------------------------------------
	// Timing units
	// ----------------------------------------------------------------
	for (genvar u = 0; u < 2; u++)
	begin : g_unit
		logic [dtp_pkg::PRE_W-1:0] pre;
		logic [dtp_pkg::PRE_W-1:0] mask;

		// Free prescaler; a unit tick fires once every 2^n timer ticks
		assign mask        = divMask(unitCfg[u].divSel);
		assign unitTick[u] = timerTick && ((pre & mask) == mask);
		assign wrap[u]     = unitTick[u] && (cnt[u] >= (cycAct[u] - 16'h0001));

		always_ff @(posedge mclk)
		begin
			if (reset)
				pre <= '0;
			else if (timerTick)
				pre <= pre + 1'b1;
		end

		// Modulo counter with shadows reloaded only at the cycle boundary
		always_ff @(posedge mclk)
		begin
			if (reset)
			begin
				cnt[u]         <= 16'h0000;
				cycAct[u]      <= dtp_pkg::CYCLE_RST;
				widthAct[u][0] <= dtp_pkg::WIDTH_RST;
				widthAct[u][1] <= dtp_pkg::WIDTH_RST;
			end
			else if (wrap[u])
			begin
				cnt[u]         <= 16'h0000;
				cycAct[u]      <= wide[u];
				widthAct[u][0] <= wide[2 + u];
				widthAct[u][1] <= wide[4 + u];
			end
			else if (unitTick[u])
				cnt[u] <= cnt[u] + 16'h0001;
		end

		// Counter below width: zero never fires, width >= cycle always does
		assign act[u][0] = cnt[u] < widthAct[u][0];
		assign act[u][1] = cnt[u] < widthAct[u][1];
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// Registered so the pins never glitch while the comparators settle
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			hwOneOut   <= 1'b0;
			hwOneOe    <= 1'b0;
			hwTwoOut   <= 1'b0;
			hwTwoOe    <= 1'b0;
			swThreeOut <= 1'b0;
			swThreeOe  <= 1'b0;
			swFourOut  <= 1'b0;
			swFourOe   <= 1'b0;
		end
		else
		begin
			hwOneOut   <= unitCfg[0].modOff ? unitCfg[0].invert
				: (act[0][0] ^ unitCfg[0].invert);
			hwOneOe    <= !(unitCfg[0].modOff && unitCfg[0].senseIn);
			hwTwoOut   <= unitCfg[1].modOff ? unitCfg[1].invert
				: (act[1][0] ^ unitCfg[1].invert);
			hwTwoOe    <= !analogOn;
			swThreeOut <= act[0][1] ^ unitCfg[0].invert;
			swThreeOe  <= !sinkOn;
			swFourOut  <= act[1][1] ^ unitCfg[1].invert;
			swFourOe   <= !genIoOn;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// Judged at the pins, so a broken compare or invert path is caught too
	a_zero_width_idle: assert property ((widthAct[0][1] == 16'h0000)
		|=> (swThreeOut == $past(unitCfg[0].invert)))
		else $error("zero width produced a pulse");
	a_full_width_on: assert property (!unitCfg[1].modOff
		&& (widthAct[1][0] >= cycAct[1]) |=> (hwTwoOut == !$past(unitCfg[1].invert)))
		else $error("full width dropped the pulse");
	a_cycle_wrap_zero: assert property (wrap[0] |=> (cnt[0] == 16'h0000))
		else $error("counter did not restart at cycle end");
	a_cycle_bound: assert property (cnt[0] < cycAct[0])
		else $error("counter ran past cycle length");
	a_width_held: assert property (!wrap[0] |=> $stable(widthAct[0][0]))
		else $error("width changed inside a cycle");
	a_polarity_out: assert property ((!unitCfg[0].modOff)
		|=> (hwOneOut == ($past(act[0][0]) ^ $past(unitCfg[0].invert))))
		else $error("channel one sense wrong");
	a_direct_drive: assert property ((unitCfg[1].modOff && !$past(reset))
		|=> (hwTwoOut == $past(unitCfg[1].invert)))
		else $error("direct output does not follow invert");
	a_sense_release: assert property ((unitCfg[0].modOff && unitCfg[0].senseIn)
		|=> !hwOneOe)
		else $error("pin still driven in sensing mode");
	a_func_disable: assert property ($rose(sinkOn) |=> !swThreeOe)
		else $error("channel three kept pin after sink enable");
	a_high_stages: assert property ((wrEn && isWide && !idx[0]) |=> $stable(wide[wideSel]))
		else $error("high byte write changed the register");
	a_cycle_clamped: assert property ((wide[0] != 16'h0000) && (wide[1] != 16'h0000))
		else $error("stored cycle length is zero");
	a_tick_gated: assert property ((unitCfg[1].divSel == 3'h0)
		|-> (unitTick[1] == timerTick))
		else $error("undivided unit tick differs from timer tick");

	c_full_cycle: cover property (wrap[0] ##1 (cnt[0] == 16'h0000));
	c_sense_mode: cover property (unitCfg[0].modOff && unitCfg[0].senseIn && pinSync);
	c_width_load: cover property (wrap[1] && (wide[3] != widthAct[1][0]));
	c_bad_access: cover property (pslverr);

endmodule : dtp_dual_timebase_pwm

// [dtp_pin_load.sv]
`timescale 1ns/1ps
module dtp_pin_load (
	input  wire logic        mclk,       // Bench clock
	input  wire logic        clear,      // Restart the tallies
	input  wire logic        extLevel,   // Sensor level on pin one
	input  wire logic        hwOneOut,   // Device drive, pin one
	input  wire logic        hwOneOe,    // Device owns pin one
	input  wire logic        hwTwoOut,   // Device drive, pin two
	input  wire logic        swThreeOut, // Device drive, sink pin
	input  wire logic        swFourOut,  // Device drive, general pin
	output logic             pinOne,     // Resolved pin one level
	output logic [15:0]      highOne,    // High cycles, pin one
	output logic [15:0]      highTwo,    // High cycles, pin two
	output logic [15:0]      highThree,  // High cycles, sink pin
	output logic [15:0]      highFour,   // High cycles, general pin
	output logic [15:0]      risesOne    // Rising edges, pin one
);
	logic lastOne;
	// ----------------------------------------------------------------
	// Pin one wire
	// ----------------------------------------------------------------
	// The sensor only wins when the device lets go of the pin
	assign pinOne = hwOneOe ? hwOneOut : extLevel;
	// Loads integrate their pins; whole periods make the tally phase free
	always_ff @(posedge mclk)
	begin
		lastOne <= pinOne;
		if (clear)
		begin
			highOne   <= 16'h0000;
			highTwo   <= 16'h0000;
			highThree <= 16'h0000;
			highFour  <= 16'h0000;
			risesOne  <= 16'h0000;
		end
		else
		begin
			highOne   <= highOne + 16'(pinOne);
			highTwo   <= highTwo + 16'(hwTwoOut);
			highThree <= highThree + 16'(swThreeOut);
			highFour  <= highFour + 16'(swFourOut);
			risesOne  <= risesOne + 16'(pinOne & ~lastOne);
		end
	end
endmodule : dtp_pin_load

// [dtp_pkg.sv]
// Operation
// - Two independent timing units; unit A paces channels one and three, unit B two and four.
// - Each unit counts modulo its 16-bit cycle length; largest usable value 65535.
// - A pulse width of zero never asserts the pulse.
// - A pulse width at or above the cycle length holds the active level.
// - Widths in between give one pulse per cycle, that many ticks long.
// - Invert bit 0: pulse high, idle low; bit 1: pulse low, idle high.
// - Modulator off without input sensing: hardware pin follows the invert bit.
// - Modulator off plus sensing on unit A: pin is input, level reads as invert bit.
// - Divide select n divides the 16 MHz timer clock by two to the n; the default timer strobe runs at 16.67 MHz.
// - A new pulse width takes effect only when the current cycle ends.
// - Channels three and four share the sink and general pins; each runs only when freed.
// - Analog, sink and general enables switch off channels two, three and four.
// - Multi-byte registers are big endian, high byte at the lower index.
// - Writes to read-only or unmapped locations change nothing.
// - A 16-bit register takes its new value when its high-index byte is written.
// - Out-of-range values are clamped into range when stored.
package dtp_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int            ADDR_W         = 8;
	localparam int            IDX_W          = 6;
	localparam logic [5:0]    IDX_ANALOG_CFG = 6'h02;
	localparam logic [5:0]    IDX_SINK_CFG   = 6'h04;
	localparam logic [5:0]    IDX_GEN_IO_CFG = 6'h05;
	localparam logic [5:0]    IDX_UNIT_A_CFG = 6'h08;
	localparam logic [5:0]    IDX_UNIT_B_CFG = 6'h09;
	localparam logic [5:0]    IDX_WIDE_FIRST = 6'h0A;
	localparam logic [5:0]    IDX_WIDE_LAST  = 6'h15;
	localparam int            WIDE_N         = 6;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int            FUNC_ON_BIT    = 4;
	localparam int            CFG_INVERT     = 7;
	localparam int            CFG_SENSE      = 5;
	localparam int            CFG_MOD_OFF    = 4;
	localparam int            DIV_W          = 3;
	localparam int            PRE_W          = 7;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [15:0]   CYCLE_RST      = 16'hFFFF;
	localparam logic [15:0]   WIDTH_RST      = 16'h0000;
	localparam logic [15:0]   CYCLE_MIN      = 16'h0001;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int            MCLK_HZ        = 200_000_000;
	localparam int            TIMER_HZ       = 16_000_000;
	localparam int            TICK_DIV       = MCLK_HZ / TIMER_HZ;

	typedef struct packed {
		logic                invert;
		logic                senseIn;
		logic                modOff;
		logic [DIV_W-1:0]    divSel;
	} dtp_unit_cfg_t;

endpackage : dtp_pkg

// [dual_timebase_pwm_tb.sv]
`timescale 1ns/1ps
module dual_timebase_pwm_tb;
	logic        mclk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pinOne;
	logic        extLevel;
	logic        clear;
	logic        hwOneOut, hwOneOe, hwTwoOut, hwTwoOe;
	logic        swThreeOut, swThreeOe, swFourOut, swFourOe;
	logic [15:0] highOne, highTwo, highThree, highFour, risesOne;
	logic [31:0] rd;
	logic        err;
	int          fails = 0;
	int          checks = 0;
	int          cyc = 0;

	// ----------------------------------------------------------------
	// Clock, timeout and instances
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end
	// The reset cycle length alone takes about 65.5k clocks; the run needs about 82k
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 95000)
		begin
			fails = fails + 1;
			complete_run();
		end
	end
	// One timer tick per clock keeps the long reset cycle inside the run budget
	dtp_dual_timebase_pwm #(.TICK_DIV(1)) i_dut (.mclk(mclk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hwOneIn(pinOne), .hwOneOut(hwOneOut),
		.hwOneOe(hwOneOe), .hwTwoOut(hwTwoOut), .hwTwoOe(hwTwoOe), .swThreeOut(swThreeOut),
		.swThreeOe(swThreeOe), .swFourOut(swFourOut), .swFourOe(swFourOe));
	dtp_pin_load i_load (.mclk(mclk), .clear(clear), .extLevel(extLevel), .hwOneOut(hwOneOut),
		.hwOneOe(hwOneOe), .hwTwoOut(hwTwoOut), .swThreeOut(swThreeOut), .swFourOut(swFourOut),
		.pinOne(pinOne), .highOne(highOne), .highTwo(highTwo), .highThree(highThree),
		.highFour(highFour), .risesOne(risesOne));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks = checks + 1;
		if (seen !== exp)
		begin
			fails = fails + 1;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
		@(posedge mclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= {idx, 2'h0};
		pwdata  <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'h1;
		@(posedge mclk);
		while (pready !== 1'h1) @(posedge mclk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// High byte first stages, low byte commits
	task automatic wr16(input logic [5:0] idx, input logic [15:0] v);
		apb(1'h1, idx, v[15:8]);
		apb(1'h1, idx + 6'h01, v[7:0]);
	endtask : wr16
	task automatic rd16(input string what, input logic [5:0] idx, input logic [15:0] exp);
		logic [7:0] hi;
		apb(1'h0, idx, 8'h00);
		hi = rd[7:0];
		apb(1'h0, idx + 6'h01, 8'h00);
		chk(what, {16'h0000, hi, rd[7:0]}, {16'h0000, exp});
	endtask : rd16
	// Tally exactly n clocks of pin activity
	task automatic measure(input int n);
		@(posedge mclk);
		clear <= 1'h1;
		@(posedge mclk);
		clear <= 1'h0;
		repeat (n) @(posedge mclk);
		#1;
	endtask : measure

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic reset_and_unmapped();
		rd16("cycle A reset", 6'h0A, 16'hFFFF);
		chk("mapped err", {31'h0, err}, 32'h0);
		rd16("width 1 reset", 6'h0E, 16'h0000);
		apb(1'h1, 6'h30, 8'h5A);
		apb(1'h0, 6'h30, 8'h00);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
	endtask : reset_and_unmapped
	task automatic clamp_and_stage();
		wr16(6'h0C, 16'h0000);
		rd16("cycle B clamp", 6'h0C, 16'h0001);
		apb(1'h1, 6'h0C, 8'h12);
		rd16("cycle B staged", 6'h0C, 16'h0001);
		apb(1'h1, 6'h0D, 8'h34);
		rd16("cycle B order", 6'h0C, 16'h1234);
	endtask : clamp_and_stage
	task automatic enables();
		logic [5:0] idx [3];
		idx = '{dtp_pkg::IDX_ANALOG_CFG, dtp_pkg::IDX_SINK_CFG, dtp_pkg::IDX_GEN_IO_CFG};
		for (int k = 0; k < 3; k++)
		begin
			apb(1'h1, idx[k], 8'h10);
			repeat (3) @(posedge mclk);
			chk("owner off", 32'({swFourOe, swThreeOe, hwTwoOe}), 32'(3'h7 ^ (3'h1 << k)));
			apb(1'h1, idx[k], 8'h00);
			repeat (3) @(posedge mclk);
			chk("owner on", 32'({swFourOe, swThreeOe, hwTwoOe}), 32'h7);
		end
	endtask : enables
	task automatic direct_pin();
		apb(1'h1, dtp_pkg::IDX_UNIT_A_CFG, 8'h90);
		repeat (3) @(posedge mclk);
		chk("pin high", 32'({hwOneOe, hwOneOut}), 32'h3);
		apb(1'h1, dtp_pkg::IDX_UNIT_A_CFG, 8'h10);
		repeat (3) @(posedge mclk);
		chk("pin low", 32'({hwOneOe, hwOneOut}), 32'h2);
		for (int k = 0; k < 2; k++)
		begin
			extLevel <= k[0];
			apb(1'h1, dtp_pkg::IDX_UNIT_A_CFG, 8'hB0);
			repeat (5) @(posedge mclk);
			apb(1'h0, dtp_pkg::IDX_UNIT_A_CFG, 8'h00);
			chk("pin sensed", {31'h0, rd[7]}, {31'h0, k[0]});
			chk("pin released", {31'h0, hwOneOe}, 32'h0);
		end
		apb(1'h1, dtp_pkg::IDX_UNIT_A_CFG, 8'h00);
	endtask : direct_pin
	// 1600 ticks keeps both units at 10 kHz of timer rate with soft channels on
	task automatic pwm_shapes();
		wr16(6'h0A, 16'd1600);
		wr16(6'h0C, 16'd1600);
		wr16(6'h0E, 16'd400);
		wr16(6'h10, 16'd1600);
		wr16(6'h12, 16'd0);
		wr16(6'h14, 16'd500);
		apb(1'h1, dtp_pkg::IDX_UNIT_B_CFG, 8'h80);
		measure(3200);
		chk("old width held", 32'(highOne), 32'h0);
		// The reset cycle length runs out first; new widths load at its end
		while (cyc < 20 + int'(dtp_pkg::CYCLE_RST) + 100) @(posedge mclk);
		measure(3200);
		chk("ch1 high", 32'(highOne), 32'd800);
		chk("ch1 rises", 32'(risesOne), 32'd2);
		// Unit B is inverted, so a full-width pulse holds its pin low
		chk("ch2 full", 32'(highTwo), 32'd0);
		chk("ch3 none", 32'(highThree), 32'd0);
		chk("ch4 inverted", 32'(highFour), 32'd2200);
	endtask : pwm_shapes
	task automatic prescale();
		apb(1'h1, dtp_pkg::IDX_UNIT_A_CFG, 8'h01);
		repeat (6400) @(posedge mclk);
		measure(6400);
		chk("div2 high", 32'(highOne), 32'd1600);
		chk("div2 rises", 32'(risesOne), 32'd2);
		chk("unit B kept", 32'(highFour), 32'd4400);
	endtask : prescale

	// ----------------------------------------------------------------
	// Verdict and main sequence
	// ----------------------------------------------------------------
	task automatic complete_run();
		if (fails == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	initial
	begin
		reset    = 1'h1;
		psel     = 1'h0;
		penable  = 1'h0;
		pwrite   = 1'h0;
		paddr    = 8'h00;
		pwdata   = 32'h0;
		extLevel = 1'h0;
		clear    = 1'h1;
		repeat (20) @(posedge mclk);
		reset <= 1'h0;
		reset_and_unmapped();
		clamp_and_stage();
		enables();
		direct_pin();
		pwm_shapes();
		prescale();
		complete_run();
	end
endmodule : dual_timebase_pwm_tb
